// *** hdl/mrad_pkg.sv ***
package mrad_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFS_CTRL_S  = 8'h00;
  localparam logic [7:0] OFS_CTRL_NS = 8'h04;
  localparam logic [7:0] OFS_PTAB_S  = 8'h08;
  localparam logic [7:0] OFS_PTAB_NS = 8'h0c;
  localparam logic [7:0] OFS_NTAB_S  = 8'h10;
  localparam logic [7:0] OFS_NTAB_NS = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;

  // ****************************************
  // control word fields and reset values
  // ****************************************
  localparam int unsigned CTRL_MMU_BIT    = 0;
  localparam int unsigned CTRL_ICACHE_BIT = 12;
  localparam int unsigned CTRL_REMAP_BIT  = 28;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK       = 32'h1000_1001;
  // all regions remap to strongly ordered after reset
  localparam logic [31:0] PTAB_RST        = 32'h0000_0000;
  localparam logic [31:0] NTAB_RST        = 32'h0000_0000;
  localparam int unsigned PTAB_SHR_BASE   = 16;
  localparam int unsigned NTAB_OUTER_BASE = 16;

  // ****************************************
  // memory types and cache policy pairs
  // ****************************************
  typedef logic [1:0] mrad_mtype_t;
  localparam mrad_mtype_t MT_SO   = 2'h0;
  localparam mrad_mtype_t MT_DEV  = 2'h1;
  localparam mrad_mtype_t MT_NORM = 2'h2;

  typedef logic [1:0] mrad_pol_t;
  localparam mrad_pol_t POL_NC   = 2'h0;
  localparam mrad_pol_t POL_WBWA = 2'h1;
  localparam mrad_pol_t POL_WTNA = 2'h2;
  localparam mrad_pol_t POL_WBNA = 2'h3;

  // bus cache codes: bit0 bufferable, bit1 cacheable, bit2 ralloc, bit3 walloc
  localparam logic [3:0] CC_SO   = 4'h0;
  localparam logic [3:0] CC_DEV  = 4'h1;
  localparam logic [3:0] CC_NC   = 4'h3;
  localparam logic [3:0] CC_WTNA = 4'h6;
  localparam logic [3:0] CC_WBNA = 4'h7;
  localparam logic [3:0] CC_WBWA = 4'hf;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       write;
    logic       instr;
    logic       secure;
    logic       has_ext;
    logic       has_shared;
    logic [2:0] type_extension_field;
    logic       cacheable;
    logic       bufferable;
    logic       shared;
  } mrad_req_s;

  typedef struct packed {
    mrad_mtype_t mtype;
    logic        shared;
    mrad_pol_t   inner;
    mrad_pol_t   outer;
  } mrad_attr_s;

  localparam mrad_attr_s ATTR_SO_SHR = '{MT_SO, 1'b1, POL_NC, POL_NC};

  function automatic logic [3:0] cache_code(input mrad_mtype_t mt, input mrad_pol_t pol);
    logic [3:0] cc;
    cc = CC_SO;
    if (mt == MT_DEV) begin
      cc = CC_DEV;
    end else if (mt != MT_SO) begin
      unique case (pol)
        POL_NC:   cc = CC_NC;
        POL_WBWA: cc = CC_WBWA;
        POL_WTNA: cc = CC_WTNA;
        default:  cc = CC_WBNA;
      endcase
    end
    return cc;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// *** hdl/mrad_remap.sv ***
`timescale 1ns/1ps
module mrad_remap (
  // remap tables of the requesting world
  input  wire logic [31:0]         i_primary_region_remap_reg,
  input  wire logic [31:0]         i_normal_region_remap_reg,
  // descriptor bits
  input  wire logic                i_ext0,
  input  wire logic                i_cacheable,
  input  wire logic                i_bufferable,
  input  wire logic                i_shared,
  // remapped attributes
  output mrad_pkg::mrad_attr_s     o_attr
);

  // ****************************************
  // table lookup
  // ****************************************
  logic [2:0]            idx;
  logic [1:0]            prim;
  mrad_pkg::mrad_mtype_t mt;

  assign idx  = {i_ext0, i_cacheable, i_bufferable};
  assign prim = i_primary_region_remap_reg[{idx, 1'b0} +: 2];
  // the fourth primary code is taken as normal memory
  assign mt   = (prim == 2'h3) ? mrad_pkg::MT_NORM : prim;

  always_comb begin
    o_attr.mtype  = mt;
    o_attr.inner  = i_normal_region_remap_reg[{idx, 1'b0} +: 2];
    o_attr.outer  = i_normal_region_remap_reg[mrad_pkg::NTAB_OUTER_BASE + {idx, 1'b0} +: 2];
    o_attr.shared = 1'b1;
    if (mt == mrad_pkg::MT_DEV) begin
      o_attr.shared = i_primary_region_remap_reg[mrad_pkg::PTAB_SHR_BASE + {4'h0, i_shared}];
    end else if (mt == mrad_pkg::MT_NORM) begin
      o_attr.shared = i_primary_region_remap_reg[mrad_pkg::PTAB_SHR_BASE + 2 + {4'h0, i_shared}];
    end
  end

endmodule

// *** hdl/mrad_top.sv ***
`timescale 1ns/1ps
// What this block does
// RULE_01 - ctrl bit 28 enables remap, three bits
// RULE_02 - remap on: upper extension bits ignored
// RULE_03 - missing shared bit reads as zero
// RULE_04 - remap enable banked per security world
// RULE_05 - remap bit decoded live, never cached
// RULE_06 - inner policy on four-bit read/write sidebands
// RULE_07 - outer policy on arcache and awcache
// RULE_08 - remap off: five bits, missing extension 000
// RULE_09 - extension 010 device always non-shared
// RULE_10 - 000 uncached: ordered or device, shared
// RULE_11 - 000 cached and 001 noncached are normal
// RULE_12 - 001 write-back allocate; l1 never allocates
// RULE_13 - top extension bit: outer/inner policy pairs
// RULE_14 - policy pair encoding nc, wbwa, wtna, wbna
// RULE_15 - outer system downgrades unsupported policies
// RULE_16 - translation off: data shared strongly ordered; with remap on the code takes remap entry zero instead
// RULE_17 - translation off, icache on: fetch write-through; with remap on the code takes remap entry zero instead
// RULE_18 - translation off, icache off: fetch ordered; with remap on the code takes remap entry zero instead
// RULE_19 - remap on: banked remap registers give attributes
// RULE_20 - reserved encodings give strongly ordered shared
module mrad_top #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_nrst,
  // avalon-mm register slave
  input  wire logic [ADDR_W-1:0]    i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // translated access request
  input  wire logic                 i_req_valid,
  input  wire mrad_pkg::mrad_req_s  i_req,
  // decoded attributes toward the memory system
  output logic                      o_attr_valid,
  output mrad_pkg::mrad_attr_s      o_attr,
  output logic      [3:0]           o_arcache,
  output logic      [3:0]           o_awcache,
  output logic      [3:0]           o_read_inner_attr_sideband,
  output logic      [3:0]           o_write_inner_attr_sideband,
  output mrad_pkg::mrad_pol_t       o_l1_inner_policy
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("mrad_top: ADDR_W must lie in 5..8");
  end

  // ****************************************
  // register bus
  // ****************************************
  logic                 ack_r;
  logic [31:0]          ctrl_s_r;
  logic [31:0]          ctrl_ns_r;
  logic [31:0]          ptab_s_r;
  logic [31:0]          ptab_ns_r;
  logic [31:0]          ntab_s_r;
  logic [31:0]          ntab_ns_r;
  logic [31:0]          rd_nxt;
  logic [7:0]           addr;
  logic                 wr_go;

  assign addr              = 8'(i_avs_address);
  // one wait cycle per access keeps read data registered
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_go             = i_avs_write & ~ack_r;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end
  end

  always_comb begin
    unique case (addr)
      mrad_pkg::OFS_CTRL_S:  rd_nxt = ctrl_s_r;
      mrad_pkg::OFS_CTRL_NS: rd_nxt = ctrl_ns_r;
      mrad_pkg::OFS_PTAB_S:  rd_nxt = ptab_s_r;
      mrad_pkg::OFS_PTAB_NS: rd_nxt = ptab_ns_r;
      mrad_pkg::OFS_NTAB_S:  rd_nxt = ntab_s_r;
      mrad_pkg::OFS_NTAB_NS: rd_nxt = ntab_ns_r;
      mrad_pkg::OFS_STATUS:  rd_nxt = {24'h0, o_attr_valid, o_attr};
      default:               rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack_r) begin
      o_avs_readdata <= rd_nxt;
    end
  end

  // ****************************************
  // banked control words
  // ****************************************
  // separate copies per world; only mmu, icache and remap bits are kept
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_s_r  <= mrad_pkg::CTRL_RST;
      ctrl_ns_r <= mrad_pkg::CTRL_RST;
    end else if (wr_go) begin
      if (addr == mrad_pkg::OFS_CTRL_S) begin
        ctrl_s_r <= mrad_pkg::be_merge(ctrl_s_r, i_avs_writedata, i_avs_byteenable)
                    & mrad_pkg::CTRL_MASK; // RULE_04
      end
      if (addr == mrad_pkg::OFS_CTRL_NS) begin
        ctrl_ns_r <= mrad_pkg::be_merge(ctrl_ns_r, i_avs_writedata, i_avs_byteenable)
                     & mrad_pkg::CTRL_MASK; // RULE_04
      end
    end
  end

  // ****************************************
  // banked remap tables
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptab_s_r  <= mrad_pkg::PTAB_RST;
      ptab_ns_r <= mrad_pkg::PTAB_RST;
    end else if (wr_go) begin
      if (addr == mrad_pkg::OFS_PTAB_S) begin
        ptab_s_r <= mrad_pkg::be_merge(ptab_s_r, i_avs_writedata, i_avs_byteenable);
      end
      if (addr == mrad_pkg::OFS_PTAB_NS) begin
        ptab_ns_r <= mrad_pkg::be_merge(ptab_ns_r, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ntab_s_r  <= mrad_pkg::NTAB_RST;
      ntab_ns_r <= mrad_pkg::NTAB_RST;
    end else if (wr_go) begin
      if (addr == mrad_pkg::OFS_NTAB_S) begin
        ntab_s_r <= mrad_pkg::be_merge(ntab_s_r, i_avs_writedata, i_avs_byteenable);
      end
      if (addr == mrad_pkg::OFS_NTAB_NS) begin
        ntab_ns_r <= mrad_pkg::be_merge(ntab_ns_r, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // ****************************************
  // world selection and descriptor cleanup
  // ****************************************
  logic [31:0]          ctrl;
  logic [31:0]          ptab;
  logic [31:0]          ntab;
  logic                 attr_remap_enable;
  logic                 mmu_on;
  logic                 icache_on;
  logic [2:0]           ext;
  logic                 s_bit;

  // the remap bit is read live from the banked copy on every access
  assign ctrl              = i_req.secure ? ctrl_s_r : ctrl_ns_r; // RULE_04
  assign ptab              = i_req.secure ? ptab_s_r : ptab_ns_r; // RULE_19
  assign ntab              = i_req.secure ? ntab_s_r : ntab_ns_r; // RULE_19
  assign attr_remap_enable = ctrl[mrad_pkg::CTRL_REMAP_BIT]; // RULE_01 RULE_05
  assign mmu_on            = ctrl[mrad_pkg::CTRL_MMU_BIT];
  assign icache_on         = ctrl[mrad_pkg::CTRL_ICACHE_BIT]; // RULE_17
  assign ext               = i_req.has_ext ? i_req.type_extension_field : 3'h0; // RULE_08
  assign s_bit             = i_req.has_shared & i_req.shared; // RULE_03

  // ****************************************
  // remapped decode
  // ****************************************
  mrad_pkg::mrad_attr_s remap_attr;
  logic                 rm_ext0;
  logic                 rm_c;
  logic                 rm_b;
  logic                 rm_s;

  // with translation off the remap uses entry zero and a shared bit of one
  assign rm_ext0 = mmu_on & ext[0]; // RULE_02
  assign rm_c    = mmu_on & i_req.cacheable;
  assign rm_b    = mmu_on & i_req.bufferable;
  assign rm_s    = ~mmu_on | s_bit; // RULE_03

  mrad_remap u_remap (
    .i_primary_region_remap_reg (ptab),
    .i_normal_region_remap_reg  (ntab),
    .i_ext0                     (rm_ext0),
    .i_cacheable                (rm_c),
    .i_bufferable               (rm_b),
    .i_shared                   (rm_s),
    .o_attr                     (remap_attr)
  );

  // ****************************************
  // direct decode
  // ****************************************
  mrad_pkg::mrad_attr_s direct_attr;

  always_comb begin
    direct_attr = mrad_pkg::ATTR_SO_SHR; // RULE_20
    if (ext[2]) begin
      direct_attr = '{mrad_pkg::MT_NORM, s_bit, {i_req.cacheable, i_req.bufferable},
                      ext[1:0]}; // RULE_13 RULE_14
    end else begin
      unique case ({ext[1:0], i_req.cacheable, i_req.bufferable})
        4'h0: direct_attr = mrad_pkg::ATTR_SO_SHR; // RULE_10
        4'h1: direct_attr = '{mrad_pkg::MT_DEV, 1'b1, mrad_pkg::POL_NC,
                              mrad_pkg::POL_NC}; // RULE_10
        4'h2: direct_attr = '{mrad_pkg::MT_NORM, s_bit, mrad_pkg::POL_WTNA,
                              mrad_pkg::POL_WTNA}; // RULE_11
        4'h3: direct_attr = '{mrad_pkg::MT_NORM, s_bit, mrad_pkg::POL_WBNA,
                              mrad_pkg::POL_WBNA}; // RULE_11
        4'h4: direct_attr = '{mrad_pkg::MT_NORM, s_bit, mrad_pkg::POL_NC,
                              mrad_pkg::POL_NC}; // RULE_11
        4'h7: direct_attr = '{mrad_pkg::MT_NORM, s_bit, mrad_pkg::POL_WBWA,
                              mrad_pkg::POL_WBWA}; // RULE_12
        4'h8: direct_attr = '{mrad_pkg::MT_DEV, 1'b0, mrad_pkg::POL_NC,
                              mrad_pkg::POL_NC}; // RULE_09
        default: direct_attr = mrad_pkg::ATTR_SO_SHR; // RULE_20
      endcase
    end
  end

  // ****************************************
  // translation-off defaults
  // ****************************************
  mrad_pkg::mrad_attr_s flat_attr;

  always_comb begin
    flat_attr = mrad_pkg::ATTR_SO_SHR; // RULE_16 RULE_18
    if (i_req.instr && icache_on) begin
      flat_attr = '{mrad_pkg::MT_NORM, 1'b0, mrad_pkg::POL_WTNA,
                    mrad_pkg::POL_WTNA}; // RULE_17
    end
  end

  // ****************************************
  // final selection
  // ****************************************
  mrad_pkg::mrad_attr_s attr_nxt;

  always_comb begin
    if (attr_remap_enable) begin
      attr_nxt = remap_attr; // RULE_01 RULE_19
    end else if (!mmu_on) begin
      attr_nxt = flat_attr; // RULE_16
    end else begin
      attr_nxt = direct_attr; // RULE_08
    end
  end

  // ****************************************
  // attribute outputs
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_attr_valid <= 1'b0;
      o_attr       <= mrad_pkg::ATTR_SO_SHR;
    end else begin
      o_attr_valid <= i_req_valid;
      if (i_req_valid) begin
        o_attr <= attr_nxt;
      end
    end
  end

  // the outer system maps policies it lacks; the code shows the requested one
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arcache                  <= mrad_pkg::CC_SO;
      o_awcache                  <= mrad_pkg::CC_SO;
      o_read_inner_attr_sideband <= mrad_pkg::CC_SO;
      o_write_inner_attr_sideband <= mrad_pkg::CC_SO;
    end else if (i_req_valid) begin
      if (i_req.write) begin
        o_awcache <= mrad_pkg::cache_code(attr_nxt.mtype, attr_nxt.outer); // RULE_07 RULE_15
        o_write_inner_attr_sideband <= mrad_pkg::cache_code(attr_nxt.mtype,
                                                            attr_nxt.inner); // RULE_06
      end else begin
        o_arcache <= mrad_pkg::cache_code(attr_nxt.mtype, attr_nxt.outer); // RULE_07
        o_read_inner_attr_sideband <= mrad_pkg::cache_code(attr_nxt.mtype,
                                                           attr_nxt.inner); // RULE_06
      end
    end
  end

  // level one never allocates on a write miss, so write-allocate folds away
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_l1_inner_policy <= mrad_pkg::POL_NC;
    end else if (i_req_valid) begin
      if (attr_nxt.mtype != mrad_pkg::MT_NORM) begin
        o_l1_inner_policy <= mrad_pkg::POL_NC;
      end else if (attr_nxt.inner == mrad_pkg::POL_WBWA) begin
        o_l1_inner_policy <= mrad_pkg::POL_WBNA; // RULE_12
      end else begin
        o_l1_inner_policy <= attr_nxt.inner;
      end
    end
  end

endmodule

// *** bench/mrad_outer_mem.sv ***
`timescale 1ns/1ps
// ********
// outer memory system: policy it really applies
// ********
module mrad_outer_mem #(
  parameter bit HAS_WT = 1'b1,
  parameter bit HAS_WB = 1'b0
) (
  // outer cache code from the core
  input  wire logic [3:0] i_cache,
  // effective outer policy
  output logic      [3:0] o_eff
);
  logic [3:0] wb_fix;
  // allocation bits are hints only, so a downgrade keeps at most ralloc; the noncached code drops both
  assign wb_fix = (!HAS_WB && i_cache[2:0] == 3'h7) ? mrad_pkg::CC_WTNA : i_cache;
  assign o_eff  = (!HAS_WT && wb_fix == mrad_pkg::CC_WTNA) ? mrad_pkg::CC_NC : wb_fix;
endmodule

// *** bench/mrad_checker.sv ***
`timescale 1ns/1ps
module mrad_checker #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic                 i_ref_clk,
  input wire logic                 i_nrst,
  // register bus
  input wire logic [ADDR_W-1:0]    i_avs_address,
  input wire logic                 i_avs_write,
  input wire logic [31:0]          i_avs_writedata,
  input wire logic [3:0]           i_avs_byteenable,
  input wire logic                 o_avs_waitrequest,
  // request and result
  input wire logic                 i_req_valid,
  input wire mrad_pkg::mrad_req_s  i_req,
  input wire mrad_pkg::mrad_attr_s o_attr,
  input wire logic [3:0]           o_arcache,
  input wire logic [3:0]           o_read_inner_attr_sideband,
  input wire mrad_pkg::mrad_pol_t  o_l1_inner_policy
);
  // ********
  // shadow of control bits {remap, icache, translation}
  // ********
  logic [2:0] cs_r;
  logic [2:0] cn_r;
  logic [2:0] wv;
  logic [2:0] wm;
  logic [2:0] ctl;
  logic [2:0] tx;
  logic [1:0] cb;
  logic       sh;
  logic       dir;
  logic       off;
  logic       rsv;
  assign wv  = {i_avs_writedata[28], i_avs_writedata[12], i_avs_writedata[0]};
  assign wm  = {i_avs_byteenable[3], i_avs_byteenable[1], i_avs_byteenable[0]};
  assign ctl = i_req.secure ? cs_r : cn_r;
  assign tx  = i_req.has_ext ? i_req.type_extension_field : 3'h0;
  assign cb  = {i_req.cacheable, i_req.bufferable};
  assign sh  = i_req.has_shared & i_req.shared;
  assign dir = i_req_valid & ctl[0] & ~ctl[2];
  assign off = i_req_valid & ~ctl[0] & ~ctl[2];
  assign rsv = tx == 3'h3 || (tx == 3'h1 && cb inside {2'h1, 2'h2}) || (tx == 3'h2 && cb != 2'h0);
  // a write lands at the edge where it is taken, waitrequest still high
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_r <= 3'h0;
      cn_r <= 3'h0;
    end else if (i_avs_write && o_avs_waitrequest) begin
      if (i_avs_address == ADDR_W'(mrad_pkg::OFS_CTRL_S)) begin
        cs_r <= (cs_r & ~wm) | (wv & wm);
      end
      if (i_avs_address == ADDR_W'(mrad_pkg::OFS_CTRL_NS)) begin
        cn_r <= (cn_r & ~wm) | (wv & wm);
      end
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  so_dev_shared_a: assert property (
    dir && tx == 3'h0 && !cb[1] |=> o_attr.shared && o_attr.mtype == {1'b0, $past(cb[0])})
    else $error("ordered or shared device decode wrong");
  dev_nonshared_a: assert property (
    dir && tx == 3'h2 && cb == 2'h0 |=> o_attr.mtype == mrad_pkg::MT_DEV && !o_attr.shared)
    else $error("non-shared device decode wrong");
  cached_normal_a: assert property (
    dir && tx[2] |=> o_attr == {mrad_pkg::MT_NORM, $past(sh), $past(cb), $past(tx[1:0])})
    else $error("cached normal decode wrong");
  reserved_so_a: assert property (
    dir && rsv |=> o_attr == mrad_pkg::ATTR_SO_SHR)
    else $error("reserved encoding not ordered shared");
  l1_no_alloc_a: assert property (
    dir && tx == 3'h1 && cb == 2'h3 |=> o_attr.inner == mrad_pkg::POL_WBWA
      && o_l1_inner_policy == mrad_pkg::POL_WBNA)
    else $error("write allocate decode or l1 fold wrong");
  off_data_a: assert property (
    off && !i_req.instr |=> o_attr == mrad_pkg::ATTR_SO_SHR)
    else $error("untranslated data attributes wrong");
  off_fetch_ic_a: assert property (
    off && i_req.instr && ctl[1] |=> o_attr == {mrad_pkg::MT_NORM, 1'b0, 4'ha})
    else $error("untranslated cached fetch wrong");
  off_fetch_so_a: assert property (
    off && i_req.instr && !ctl[1] |=> o_attr == mrad_pkg::ATTR_SO_SHR)
    else $error("untranslated uncached fetch wrong");
  read_chan_a: assert property (
    i_req_valid && i_req.write |=> $stable(o_arcache) && $stable(o_read_inner_attr_sideband))
    else $error("write request moved read channel codes");
endmodule

bind mrad_top mrad_checker #(.ADDR_W(ADDR_W)) u_mrad_checker (
  .i_ref_clk, .i_nrst, .i_avs_address, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_waitrequest, .i_req_valid, .i_req, .o_attr, .o_arcache, .o_read_inner_attr_sideband,
  .o_l1_inner_policy
);

// *** bench/mrad_tb_top.sv ***
`timescale 1ns/1ps
module mrad_tb_top;
  localparam logic [1:0] DV = mrad_pkg::MT_DEV;
  localparam logic [1:0] NM = mrad_pkg::MT_NORM;
  localparam logic [1:0] NC = mrad_pkg::POL_NC;
  localparam logic [1:0] WA = mrad_pkg::POL_WBWA;
  localparam logic [1:0] WT = mrad_pkg::POL_WTNA;
  localparam logic [1:0] WB = mrad_pkg::POL_WBNA;
  logic                 clk;
  logic                 nrst;
  logic [7:0]           addr;
  logic                 rd;
  logic                 wr;
  logic [31:0]          wd;
  logic [3:0]           be;
  logic [31:0]          rdata;
  logic                 wreq;
  logic                 rv;
  mrad_pkg::mrad_req_s  req;
  logic                 av;
  mrad_pkg::mrad_attr_s attr;
  logic [3:0]           arc;
  logic [3:0]           awc;
  logic [3:0]           rsb;
  logic [3:0]           wsb;
  logic [3:0]           eff;
  logic [3:0]           eff_nc;
  mrad_pkg::mrad_pol_t  l1;
  logic [31:0]          q;
  int                   bad_count;
  int                   n_tests;

  mrad_top #(.ADDR_W(8)) dut (
    .i_ref_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_req_valid(rv), .i_req(req), .o_attr_valid(av), .o_attr(attr),
    .o_arcache(arc), .o_awcache(awc), .o_read_inner_attr_sideband(rsb),
    .o_write_inner_attr_sideband(wsb), .o_l1_inner_policy(l1)
  );
  mrad_outer_mem u_mem (.i_cache(arc), .o_eff(eff));
  mrad_outer_mem #(.HAS_WT(1'b0)) u_mem_nc (.i_cache(awc), .o_eff(eff_nc));

  initial begin
    clk = 1'b0;
    forever begin
      #2 clk = ~clk;
    end
  end

  // ********
  // own models of the decode
  // ********
  function automatic logic [3:0] ccode(input logic [1:0] mt, input logic [1:0] p);
    logic [15:0] tbl;
    tbl = 16'h76f3;
    return (mt == NM) ? tbl[p*4 +: 4] : {3'h0, mt == DV};
  endfunction
  function automatic mrad_pkg::mrad_attr_s dexp(input logic [2:0] t, input logic [1:0] c,
                                                input logic s);
    if (t[2]) begin
      return {NM, s, c, t[1:0]};
    end
    case ({t, c})
      5'h01: return {DV, 1'b1, NC, NC};
      5'h02: return {NM, s, WT, WT};
      5'h03: return {NM, s, WB, WB};
      5'h04: return {NM, s, NC, NC};
      5'h07: return {NM, s, WA, WA};
      5'h08: return {DV, 1'b0, NC, NC};
      default: return mrad_pkg::ATTR_SO_SHR;
    endcase
  endfunction
  function automatic mrad_pkg::mrad_req_s rq(input logic [2:0] wis, input logic [2:0] t,
                                             input logic [1:0] c, input logic s);
    return {wis, 2'h3, t, c, s};
  endfunction

  // ********
  // bus and request tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    rd   <= r;
    wr   <= ~r;
    addr <= a;
    wd   <= d;
    be   <= b;
    @(posedge clk iff wreq === 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask
  task automatic acc(input mrad_pkg::mrad_req_s r, input mrad_pkg::mrad_attr_s e);
    logic [1:0] l;
    l = (e.mtype != NM) ? NC : (e.inner == WA) ? WB : e.inner;
    rv  <= 1'b1;
    req <= r;
    @(posedge clk);
    rv <= 1'b0;
    #1;
    chk("attr_valid", 32'h1, {31'h0, av});
    chk("attr", {25'h0, e}, {25'h0, attr});
    chk("outer code", {28'h0, ccode(e.mtype, e.outer)}, {28'h0, r.write ? awc : arc});
    chk("sideband", {28'h0, ccode(e.mtype, e.inner)}, {28'h0, r.write ? wsb : rsb});
    chk("l1 policy", {30'h0, l}, {30'h0, l1});
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wd = 32'h0;
    be = 4'hf;
    rv = 1'b0;
    req = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc("ctrl reset", mrad_pkg::OFS_CTRL_S, 32'h0);
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'hffff_ffff, 4'h8);
    rdc("ctrl lane", mrad_pkg::OFS_CTRL_S, 32'h1000_0000);
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'hffff_ffff, 4'hf);
    rdc("ctrl mask", mrad_pkg::OFS_CTRL_S, 32'h1000_1001);
    bus(1'b0, 8'h1c, 32'hffff_ffff, 4'hf);
    rdc("unmapped", 8'h1c, 32'h0);
    // translation on, remap off: whole direct table, both channels
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'h0000_0001, 4'hf);
    for (int i = 0; i < 64; i++) begin
      acc(rq({i[0] ^ i[4], i[1], 1'b1}, i[5:3], i[2:1], i[0]), dexp(i[5:3], i[2:1], i[0]));
    end
    acc({3'h1, 2'h0, 3'h5, 2'h3, 1'h1}, {NM, 1'b0, WB, WB});
    chk("outer applied", {28'h0, mrad_pkg::CC_WTNA}, {28'h0, eff});
    chk("outer downgraded", {28'h0, mrad_pkg::CC_NC}, {28'h0, eff_nc});
    // translation off
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'h0, 4'hf);
    acc(rq(3'h5, 3'h4, 2'h3, 1'h0), mrad_pkg::ATTR_SO_SHR);
    acc(rq(3'h3, 3'h4, 2'h3, 1'h0), mrad_pkg::ATTR_SO_SHR);
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'h0000_1000, 4'hf);
    acc(rq(3'h3, 3'h0, 2'h0, 1'h1), {NM, 1'b0, WT, WT});
    acc(rq(3'h1, 3'h0, 2'h3, 1'h0), mrad_pkg::ATTR_SO_SHR);
    // remap on in the secure world only
    bus(1'b0, mrad_pkg::OFS_PTAB_S, 32'h0009_0086, 4'hf);
    bus(1'b0, mrad_pkg::OFS_NTAB_S, 32'h0080_0040, 4'hf);
    bus(1'b0, mrad_pkg::OFS_CTRL_NS, 32'h0000_0001, 4'hf);
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'h1000_0001, 4'hf);
    acc(rq(3'h1, 3'h6, 2'h3, 1'h1), {NM, 1'b1, WA, WT});
    acc(rq(3'h5, 3'h0, 2'h3, 1'h1), {NM, 1'b1, WA, WT});
    acc(rq(3'h1, 3'h2, 2'h1, 1'h0), {DV, 1'b1, NC, NC});
    acc(rq(3'h1, 3'h1, 2'h0, 1'h1), mrad_pkg::ATTR_SO_SHR);
    acc(rq(3'h0, 3'h6, 2'h3, 1'h1), dexp(3'h6, 2'h3, 1'h1));
    // remap on, translation off: entry zero with the shared bit forced to one
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'h1000_0000, 4'hf);
    acc(rq(3'h1, 3'h7, 2'h3, 1'h0), {NM, 1'b1, NC, NC});
    bus(1'b0, mrad_pkg::OFS_CTRL_S, 32'h0000_0001, 4'hf);
    acc(rq(3'h1, 3'h6, 2'h3, 1'h1), dexp(3'h6, 2'h3, 1'h1));
    bus(1'b0, mrad_pkg::OFS_STATUS, 32'hffff_ffff, 4'hf);
    rdc("status", mrad_pkg::OFS_STATUS, {25'h0, dexp(3'h6, 2'h3, 1'h1)});
    test_done();
  end
endmodule
